// ===== edge_detect.sv
/*
  External interrupt edge detector for the eight interrupt inputs.
  Assumes synchronised inputs on aclk.
*/
`timescale 1ns/10ps
module edge_detect (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] level,
  input wire logic [7:0] enable,
  input wire logic [7:0] gate,
  output logic [7:0] event_pulse
);
  // Inputs 1,2,5,6 rise; 3,4,7,8 fall
  localparam logic [7:0] RISING_MASK = 8'h33;
  typedef struct packed {
    logic [7:0] prev;
    logic [7:0] pulse;
  } edge_state_t;
  edge_state_t state;
  edge_state_t next_state;
  logic [7:0] rise;
  logic [7:0] fall;
  // Edge detection per input
  always_comb begin
    rise = level & ~state.prev;
    fall = ~level & state.prev;
    next_state.prev = level;
    next_state.pulse = enable & gate & ((rise & RISING_MASK) | (fall & ~RISING_MASK));
    if (!aresetn) begin
      next_state = '0;
    end
  end
  always_ff @(posedge aclk) begin
    state <= next_state;
  end
  assign event_pulse = state.pulse;
endmodule

// ===== pin_board.sv
/* Board model: resolves each pin from chip drive and board level.
   Assumes board levels come from the testbench. */
`timescale 1ns/10ps
module pin_board (
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_b_oe,
  input wire logic [2:0] port_c_out,
  input wire logic [2:0] port_c_oe,
  input wire logic [23:0] board,
  output logic [7:0] port_a_in,
  output logic [7:0] port_b_in,
  output logic [2:0] port_c_in
);
  // Driven pins follow the chip, open drain pins pull low, others follow the board
  assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & board[7:0]);
  assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & board[15:8]);
  assign port_c_in = (port_c_oe & port_c_out) | (~port_c_oe & board[18:16]);
endmodule

// ===== pin_sync.sv
/*
  Two-flop synchroniser for all pin inputs.
  Assumes pins are asynchronous to aclk.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 19
) (
  input wire logic aclk,
  input wire logic aresetn,
  pin_sync_if.sync_side pins
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;
  sync_state_t state;
  sync_state_t next_state;
  // Refuse a width the shift stages cannot hold
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync width must be positive");
  end
  // Shift pins through two stages
  always_comb begin
    next_state.first = pins.raw;
    next_state.second = state.first;
    if (!aresetn) begin
      next_state = '0;
    end
  end
  always_ff @(posedge aclk) begin
    state <= next_state;
  end
  assign pins.clean = state.second;
endmodule

// ===== pin_sync_if.sv
/*
  Interface carrying raw pins into the synchroniser and clean levels out.
  Assumes one clock for the whole block.
*/
`timescale 1ns/10ps
interface pin_sync_if #(parameter int WIDTH = 19);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] clean;
  modport sync_side (input raw, output clean);
  modport user_side (output raw, input clean);
endinterface

// ===== port_misc_top.sv
/*
  Three I/O ports (A, B, C) and the miscellaneous control register with an
  AXI4-Lite slave. Pins are split into input, output and output enable.
  Assumes on-chip peripherals drive their alternate signals on aclk.
*/
`timescale 1ns/10ps
module port_misc_top
  import port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_a_pullup,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_b_analog_route,
  input wire logic [2:0] port_c_in,
  output logic [2:0] port_c_out,
  output logic [2:0] port_c_oe,
  output logic [2:0] port_c_pullup,
  input wire logic [2:0] analog_channel_select,
  input wire logic analog_enable,
  input wire logic cpu_clock,
  input wire logic timer_compare_out1,
  input wire logic timer_compare_out2,
  input wire logic i2c_sda_out,
  input wire logic i2c_scl_out,
  input wire logic serial_transmit_out,
  input wire logic usb_transmitting,
  output logic timer_external_clock,
  output logic timer_capture_in1,
  output logic timer_capture_in2,
  output logic i2c_sda_in,
  output logic i2c_scl_in,
  output logic serial_receive_in,
  output logic [7:0] ext_irq_event,
  output logic osc_divider_select,
  output logic low_voltage_detector_off
);
  typedef enum logic [1:0] {IDLE, WRITE_RESP, READ_RESP} bus_state_t;
  typedef struct packed {
    bus_state_t bus;
    logic aw_held;
    logic w_held;
    logic [ADDR_WIDTH-1:0] waddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic [1:0] bresp;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] a_latch;
    logic [7:0] a_dir;
    logic [7:0] b_latch;
    logic [7:0] b_dir;
    logic [2:0] c_latch;
    logic [2:0] c_dir;
    logic [7:0] ext_irq_edge_enables;
    logic [3:0] misc;
    logic [5:0] periph;
    logic [7:0] irq_status;
  } top_state_t;
  top_state_t state;
  top_state_t next_state;

  // Pin synchronisers
  pin_sync_if #(.WIDTH(19)) pins ();
  assign pins.raw = {port_c_in, port_b_in, port_a_in};
  pin_sync #(.WIDTH(19)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins(pins)
  );
  logic [7:0] a_pin;
  logic [7:0] b_pin;
  logic [2:0] c_pin;
  assign a_pin = pins.clean[7:0];
  assign b_pin = pins.clean[15:8];
  assign c_pin = pins.clean[18:16];

  // Interrupt sources: port A 4-7 then port B 4-7, inputs only
  logic [7:0] irq_gate;
  logic [7:0] irq_pulse;
  assign irq_gate = {~state.b_dir[7:4], ~state.a_dir[7:4]};
  edge_detect u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level({b_pin[7:4], a_pin[7:4]}),
    .enable(state.ext_irq_edge_enables),
    .gate(irq_gate),
    .event_pulse(irq_pulse)
  );
  assign ext_irq_event = irq_pulse;

  // Alternate function claims
  logic cmp1_on;
  logic cmp2_on;
  logic i2c_on;
  logic sci_on;
  assign cmp1_on = state.periph[PC_CMP1_EN];
  assign cmp2_on = state.periph[PC_CMP2_EN];
  assign i2c_on = state.periph[PC_I2C_EN];
  assign sci_on = state.periph[PC_SCI_EN];

  // Port A drive with alternate overrides
  always_comb begin
    port_a_out = state.a_latch;
    port_a_oe = state.a_dir;
    if (state.misc[MISC_CLK_OUT]) begin
      port_a_out[0] = cpu_clock;
      port_a_oe[0] = 1'b1;
    end
    if (cmp1_on) begin
      port_a_out[6] = timer_compare_out1;
      port_a_oe[6] = 1'b1;
    end
    if (cmp2_on) begin
      port_a_out[7] = timer_compare_out2;
      port_a_oe[7] = 1'b1;
    end
    // Open drain: drive only a low level
    port_a_out[1] = 1'b0;
    port_a_out[2] = 1'b0;
    port_a_oe[1] = i2c_on ? ~i2c_sda_out : (state.a_dir[1] & ~state.a_latch[1]);
    port_a_oe[2] = i2c_on ? ~i2c_scl_out : (state.a_dir[2] & ~state.a_latch[2]);
  end
  // Pull-ups on inputs of A0, A3-A7; none on open-drain pins
  assign port_a_pullup = ~port_a_oe & 8'hF9;
  assign timer_external_clock = a_pin[3];
  assign timer_capture_in1 = a_pin[4];
  assign timer_capture_in2 = a_pin[5];
  assign i2c_sda_in = a_pin[1];
  assign i2c_scl_in = a_pin[2];

  // Port B plain push-pull, analog routing by channel code
  assign port_b_out = state.b_latch;
  assign port_b_oe = state.b_dir;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_route
      assign port_b_analog_route[gi] = analog_enable && (analog_channel_select == 3'(gi));
    end
  endgenerate

  // Port C with serial and USB enable overrides
  always_comb begin
    port_c_out = state.c_latch;
    port_c_oe = state.c_dir;
    if (sci_on) begin
      port_c_out[1] = serial_transmit_out;
      port_c_oe[1] = 1'b1;
    end
    if (state.misc[MISC_USB_OE]) begin
      port_c_out[2] = usb_transmitting;
      port_c_oe[2] = 1'b1;
    end
  end
  assign port_c_pullup = ~port_c_oe;
  assign serial_receive_in = c_pin[0];
  assign osc_divider_select = state.misc[MISC_OSC_DIV];
  assign low_voltage_detector_off = state.misc[MISC_LVD_OFF];

  // Read value per register index
  function automatic logic [7:0] read_reg(input logic [3:0] idx, input top_state_t s,
      input logic [7:0] ap, input logic [7:0] bp, input logic [2:0] cp, output logic ok);
    logic [7:0] v;
    v = 8'h00;
    ok = 1'b1;
    case (idx)
      IDX_PORT_A_DATA: v = (s.a_dir & s.a_latch) | (~s.a_dir & ap);
      IDX_PORT_A_DIRECTION: v = s.a_dir;
      IDX_PORT_B_DATA: v = (s.b_dir & s.b_latch) | (~s.b_dir & bp);
      IDX_PORT_B_DIRECTION: v = s.b_dir;
      IDX_PORT_C_DATA: v = PORT_C_UPPER | {5'h00, (s.c_dir & s.c_latch) | (~s.c_dir & cp)};
      IDX_PORT_C_DIRECTION: v = PORT_C_UPPER | {5'h00, s.c_dir};
      IDX_EXT_IRQ_EDGE: v = s.ext_irq_edge_enables;
      IDX_MISC_CONTROL: v = MISC_RESERVED | {4'h0, s.misc};
      IDX_PERIPH_CONTROL: v = {2'h0, s.periph};
      IDX_EXT_IRQ_STATUS: v = s.irq_status;
      default: ok = 1'b0;
    endcase
    return v;
  endfunction

  // Bus handshakes
  assign s_axi_awready = (state.bus == IDLE) && !state.aw_held;
  assign s_axi_wready = (state.bus == IDLE) && !state.w_held;
  assign s_axi_arready = (state.bus == IDLE) && !state.aw_held && !state.w_held;
  assign s_axi_bvalid = (state.bus == WRITE_RESP);
  assign s_axi_bresp = state.bresp;
  assign s_axi_rvalid = (state.bus == READ_RESP);
  assign s_axi_rdata = {24'h000000, state.rdata};
  assign s_axi_rresp = state.rresp;

  logic aw_now;
  logic w_now;
  logic [3:0] widx;
  logic widx_ok;
  logic [7:0] wv;
  logic rd_ok;
  logic [7:0] rd_val;
  logic do_write;

  // Next state: bus, registers and interrupt status
  always_comb begin
    next_state = state;
    aw_now = s_axi_awvalid && s_axi_awready;
    w_now = s_axi_wvalid && s_axi_wready;
    if (aw_now) begin
      next_state.aw_held = 1'b1;
      next_state.waddr = s_axi_awaddr[ADDR_WIDTH-1:0];
    end
    if (w_now) begin
      next_state.w_held = 1'b1;
      next_state.wdata = s_axi_wdata[7:0];
      next_state.wstrb0 = s_axi_wstrb[0];
    end
    widx = state.waddr[5:2];
    widx_ok = 1'b0;
    wv = state.wdata;
    do_write = (state.bus == IDLE) && state.aw_held && state.w_held;
    rd_val = read_reg(s_axi_araddr[5:2], state, a_pin, b_pin, c_pin, rd_ok);
    // Sticky interrupt status: a new event wins over a write-one clear
    if (do_write) begin
      void'(read_reg(widx, state, a_pin, b_pin, c_pin, widx_ok));
      widx_ok = widx_ok && (state.waddr[1:0] == 2'b00) && (s_axi_awaddr[31:ADDR_WIDTH] == '0 || 1'b1);
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.bus = WRITE_RESP;
      next_state.bresp = widx_ok ? RESP_OKAY : RESP_SLVERR;
      if (widx_ok && state.wstrb0) begin
        case (widx)
          IDX_PORT_A_DATA: next_state.a_latch = wv;
          IDX_PORT_A_DIRECTION: next_state.a_dir = wv;
          IDX_PORT_B_DATA: next_state.b_latch = wv;
          IDX_PORT_B_DIRECTION: next_state.b_dir = wv;
          IDX_PORT_C_DATA: next_state.c_latch = wv[2:0];
          IDX_PORT_C_DIRECTION: next_state.c_dir = wv[2:0];
          IDX_EXT_IRQ_EDGE: next_state.ext_irq_edge_enables = wv;
          IDX_MISC_CONTROL: begin
            next_state.misc[MISC_CLK_OUT] = wv[MISC_CLK_OUT];
            next_state.misc[MISC_USB_OE] = wv[MISC_USB_OE];
            next_state.misc[MISC_OSC_DIV] = state.misc[MISC_OSC_DIV] | wv[MISC_OSC_DIV];
            next_state.misc[MISC_LVD_OFF] = state.misc[MISC_LVD_OFF] | wv[MISC_LVD_OFF];
          end
          IDX_PERIPH_CONTROL: next_state.periph = wv[5:0];
          IDX_EXT_IRQ_STATUS: next_state.irq_status = state.irq_status & ~wv;
          default: next_state.bresp = RESP_SLVERR;
        endcase
      end
    end
    next_state.irq_status = next_state.irq_status | irq_pulse;
    case (state.bus)
      IDLE: begin
        if (!do_write && s_axi_arvalid && s_axi_arready) begin
          next_state.bus = READ_RESP;
          next_state.rdata = rd_val;
          // Unaligned read addresses are refused like unmapped ones
          next_state.rresp = (rd_ok && s_axi_araddr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
        end
      end
      WRITE_RESP: begin
        if (s_axi_bready) begin
          next_state.bus = IDLE;
        end
      end
      READ_RESP: begin
        if (s_axi_rready) begin
          next_state.bus = IDLE;
        end
      end
      default: next_state.bus = IDLE;
    endcase
    // Reset values
    if (!aresetn) begin
      next_state = '0;
      next_state.bus = IDLE;
      next_state.a_latch = RESET_PORT_AB;
      next_state.a_dir = RESET_PORT_AB;
      next_state.b_latch = RESET_PORT_AB;
      next_state.b_dir = RESET_PORT_AB;
      next_state.c_latch = RESET_PORT_C;
      next_state.c_dir = RESET_PORT_C;
      next_state.misc = RESET_MISC[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    state <= next_state;
  end
endmodule

// ===== port_pkg.sv
/*
  Constants shared by the port and miscellaneous control block.
  Assumes an AXI4-Lite register bus with 32-bit data.
*/
package port_pkg;
  // Register indices, byte address bits 5:2 (printed offsets are indices, not all multiples of four)
  localparam logic [3:0] IDX_PORT_A_DATA = 4'h0;
  localparam logic [3:0] IDX_PORT_A_DIRECTION = 4'h1;
  localparam logic [3:0] IDX_PORT_B_DATA = 4'h2;
  localparam logic [3:0] IDX_PORT_B_DIRECTION = 4'h3;
  localparam logic [3:0] IDX_PORT_C_DATA = 4'h4;
  localparam logic [3:0] IDX_PORT_C_DIRECTION = 4'h5;
  localparam logic [3:0] IDX_EXT_IRQ_EDGE = 4'h8;
  localparam logic [3:0] IDX_MISC_CONTROL = 4'h9;
  localparam logic [3:0] IDX_PERIPH_CONTROL = 4'hA;
  localparam logic [3:0] IDX_EXT_IRQ_STATUS = 4'hB;
  localparam int ADDR_WIDTH = 6;
  // Reset values
  localparam logic [7:0] RESET_PORT_AB = 8'h00;
  localparam logic [2:0] RESET_PORT_C = 3'h0;
  localparam logic [7:0] PORT_C_UPPER = 8'hF8;
  localparam logic [7:0] RESET_MISC = 8'hF0;
  localparam logic [7:0] MISC_RESERVED = 8'hF0;
  // Miscellaneous field positions
  localparam int MISC_CLK_OUT = 0;
  localparam int MISC_USB_OE = 1;
  localparam int MISC_OSC_DIV = 2;
  localparam int MISC_LVD_OFF = 3;
  // Peripheral control field positions
  localparam int PC_CMP1_EN = 0;
  localparam int PC_CMP2_EN = 1;
  localparam int PC_I2C_EN = 2;
  localparam int PC_SCI_EN = 3;
  localparam int PC_CLK_SEL0 = 4;
  localparam int PC_CLK_SEL1 = 5;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== port_properties.sv
/* Checker for the port and miscellaneous control block.
   Bound to port_misc_top; sees only its ports, one clock domain. */
`timescale 1ns/10ps
module port_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] port_a_pullup,
  input wire logic [7:0] port_b_analog_route,
  input wire logic [2:0] port_c_in,
  input wire logic [2:0] port_c_oe,
  input wire logic [2:0] port_c_pullup,
  input wire logic [2:0] analog_channel_select,
  input wire logic analog_enable,
  input wire logic timer_capture_in1,
  input wire logic serial_receive_in,
  input wire logic [7:0] ext_irq_event,
  input wire logic osc_divider_select,
  input wire logic low_voltage_detector_off
);
  logic [1:0] up;
  // Cycles since reset release, saturating at three
  always_ff @(posedge aclk) begin
    if (!aresetn) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  osc_set_only_a: assert property (osc_divider_select |=> osc_divider_select)
    else $error("divider select cleared without reset");
  lvd_set_only_a: assert property (low_voltage_detector_off |=> low_voltage_detector_off)
    else $error("detector off cleared without reset");
  analog_route_a: assert property (port_b_analog_route ==
    (analog_enable ? 8'h01 << analog_channel_select : 8'h00))
    else $error("analog route wrong");
  open_drain_a: assert property (port_a_out[2:1] == 2'h0 && port_a_pullup[2:1] == 2'h0)
    else $error("open drain pin drives high or pulls up");
  reset_pins_a: assert property (up == 2'h0 |-> port_a_oe == 8'h00 && port_c_oe == 3'h0
    && port_a_pullup == 8'hF9 && port_c_pullup == 3'h7)
    else $error("pins not inputs with pull-up after reset");
  irq_single_a: assert property ((ext_irq_event & $past(ext_irq_event)) == 8'h00)
    else $error("interrupt pulse longer than one cycle");
  irq_rise_a: assert property (ext_irq_event[0] |->
    $past(port_a_in[4], 3) && !$past(port_a_in[4], 4))
    else $error("input one fired without rising edge");
  irq_fall_a: assert property (ext_irq_event[2] |->
    !$past(port_a_in[6], 3) && $past(port_a_in[6], 4))
    else $error("input three fired without falling edge");
  capture_sync_a: assert property (up == 2'h3 |-> timer_capture_in1 == $past(port_a_in[4], 2))
    else $error("capture input not pin level two cycles late");
  serial_sync_a: assert property (up == 2'h3 |-> serial_receive_in == $past(port_c_in[0], 2))
    else $error("serial receive not pin level two cycles late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  cover property (ext_irq_event[0]);
  cover property (osc_divider_select);
  cover property (|port_b_analog_route);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind port_misc_top port_properties i_port_properties (
  .aclk, .aresetn, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .port_a_in, .port_a_out,
  .port_a_oe, .port_a_pullup, .port_b_analog_route, .port_c_in, .port_c_oe, .port_c_pullup,
  .analog_channel_select, .analog_enable, .timer_capture_in1, .serial_receive_in,
  .ext_irq_event, .osc_divider_select, .low_voltage_detector_off);

// ===== tb_top.sv
/* Self-checking bench for port_misc_top.
   Assumes the board model and the bound checker. */
`timescale 1ns/10ps
module tb_top
  import port_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_v, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] port_a_in, port_a_out, port_a_oe, port_a_pullup, port_b_in, port_b_out;
  logic [7:0] port_b_oe, port_b_analog_route, ext_irq_event, lat, dir, msk, od;
  logic [2:0] port_c_in, port_c_out, port_c_oe, port_c_pullup, analog_channel_select;
  logic analog_enable, cpu_clock, timer_compare_out1, timer_compare_out2, i2c_sda_out;
  logic i2c_scl_out, serial_transmit_out, usb_transmitting, timer_external_clock;
  logic timer_capture_in1, timer_capture_in2, i2c_sda_in, i2c_scl_in, serial_receive_in;
  logic osc_divider_select, low_voltage_detector_off;
  logic [23:0] board, all_out, all_oe;
  int n_mismatch, samples_checked, p, cnt;
  port_misc_top i_port_misc_top (.*);
  pin_board i_pin_board (.port_a_out, .port_a_oe, .port_b_out, .port_b_oe, .port_c_out,
    .port_c_oe, .board, .port_a_in, .port_b_in, .port_c_in);
  assign all_out = {5'h00, port_c_out, port_b_out, port_a_out};
  assign all_oe = {5'h00, port_c_oe, port_b_oe, port_a_oe};
  // Clock and random peripheral inputs
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    {analog_enable, analog_channel_select, cpu_clock, timer_compare_out1, timer_compare_out2,
      i2c_sda_out, i2c_scl_out, serial_transmit_out, usb_transmitting} <= 11'($random(seed));
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Wait for the response; only the watchdog ends a hang
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
  endtask
  task automatic rc(input int a, input logic [31:0] x, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    rsp = s_axi_rresp;
    chk({30'h0, rsp}, {30'h0, r});
    if (r == RESP_OKAY) chk(s_axi_rdata, x);
  endtask
  // Data read: latch for outputs, pin level for inputs
  function automatic logic [31:0] rdexp(int q, logic [7:0] l, logic [7:0] d, logic [7:0] x);
    logic [7:0] e;
    e = (d & l) | (~d & x);
    if (q == 2) e = {5'h1F, e[2:0]};
    return {24'h0, e};
  endfunction
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (30000) @(posedge aclk);
    n_mismatch++;
    conclude();
  end
  // Main sequence
  initial begin
    seed = 32'h8DEA96E2;
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h00;
    {s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr, board} = 121'h0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rc(i == 6 ? 36 : 4 * i, i == 6 ? 32'hF0 : i > 3 ? 32'hF8 : 0, RESP_OKAY);
    rc(24, 0, RESP_SLVERR);
    rc(1, 0, RESP_SLVERR);
    $display("reset values done");
    for (int k = 0; k < 40; k++) begin
      p = $unsigned($random(seed)) % 3;
      lat = 8'($random(seed));
      dir = 8'($random(seed));
      msk = p == 2 ? 8'h07 : 8'hFF;
      od = p == 0 ? 8'h06 : 8'h00;
      @(posedge aclk);
      board <= 24'($random(seed));
      wr(8 * p, {24'h0, lat});
      wr(8 * p + 4, {24'h0, dir});
      repeat (4) @(posedge aclk);
      rc(8 * p, rdexp(p, lat, dir, board[8 * p +: 8]), RESP_OKAY);
      rc(8 * p + 4, rdexp(p, dir, 8'hFF, 8'h00), RESP_OKAY);
      @(negedge aclk);
      chk({24'h0, all_oe[8 * p +: 8]}, {24'h0, dir & msk & ~(lat & od)});
      chk({24'h0, all_out[8 * p +: 8] & dir & msk}, {24'h0, lat & dir & msk & ~od});
      // Pins have been still for many cycles, so the synchronised copies match them
      chk({timer_external_clock, timer_capture_in2, i2c_scl_in, i2c_sda_in},
        {port_a_in[3], port_a_in[5], port_a_in[2], port_a_in[1]});
    end
    $display("random port traffic done");
    wr(4, 0);
    wr(20, 0);
    wr(40, 32'h0F);
    @(negedge aclk);
    chk({port_a_out[7:6], port_a_oe[7:6], port_c_out[1], port_c_oe[1], port_a_oe[2:1]},
      {timer_compare_out2, timer_compare_out1, 2'h3, serial_transmit_out, 1'b1,
      ~i2c_scl_out, ~i2c_sda_out});
    wr(40, 0);
    wr(36, 32'h0F);
    rc(36, 32'hFF, RESP_OKAY);
    @(negedge aclk);
    chk({port_a_out[0], port_a_oe[0], port_c_out[2], port_c_oe[2]},
      {cpu_clock, 1'b1, usb_transmitting, 1'b1});
    wr(36, 0);
    rc(36, 32'hFC, RESP_OKAY);
    chk({30'h0, low_voltage_detector_off, osc_divider_select}, 32'h3);
    $display("misc and alternate done");
    wr(12, 0);
    for (int en = 1; en >= 0; en--) begin
      wr(32, en ? 32'hFF : 0);
      for (int i = 0; i < 8; i++) begin
        p = i < 4 ? i + 4 : i + 8;
        @(posedge aclk);
        board[p] <= (i % 4) > 1;
        repeat (8) @(posedge aclk);
        board[p] <= (i % 4) < 2;
        cnt = 0;
        repeat (10) @(posedge aclk) cnt += ext_irq_event[i];
        board[p] <= (i % 4) > 1;
        repeat (10) @(posedge aclk) cnt += ext_irq_event[i];
        chk(cnt, en);
      end
    end
    // Every input fired once while enabled; status is sticky, write one clears
    rc(44, 32'hFF, RESP_OKAY);
    wr(44, 32'hFF);
    rc(44, 0, RESP_OKAY);
    $display("interrupt edges done");
    wr(36, 32'h0C);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rc(36, 32'hF0, RESP_OKAY);
    chk({30'h0, low_voltage_detector_off, osc_divider_select}, 0);
    $display("second reset done");
    conclude();
  end
endmodule
